// file: hdl/usie_pkg.sv
// ----------------------------------------------------------------------------
// Contract
// - transmitter adds sync, crc, stuffing, nrzi and end-of-packet itself
// - in request on an armed in buffer answered with a data packet
// - good data packet after an accepted out or setup token answered with ack, nak or stall
// - receiver deserialises, checks framing and stores packets in shared ram
// - nrzi decode, sync, unstuff, eop, crc and pid checks on receive
// - flag crc mismatch, stuffing violation and missing end-of-packet
// - bad packets are dropped without any handshake
// - register target port plus engine-side ram master port
// - gasket routes cpu accesses to ram or registers, holds power controls
// - endpoint and direction map to a descriptor address in ram
// - 256 byte ram, cpu and engine both served every cycle unblocked
// - spare ram is plain memory; whole ram free while usb disabled
// - regulator active while usb active
// - regulator standby on suspend; firmware then enters third level sleep
// - regulator off in first or second level sleep or when disabled
// - pullup select clear disables the internal data-plus pullup
// - internal pullup only while vbus is sensed valid
// - halted endpoint answers stall only to accesses its enables accept: in needs tx, out needs rx
// - handshake enable clear suppresses ack and nak; a halted endpoint still answers stall
// ----------------------------------------------------------------------------
package usie_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SUSPEND_MS = 3;
  localparam int SUSPEND_CYC = CLK_HZ / 1000 * SUSPEND_MS;
  localparam logic [1:0] TX_DIV_LAST = 2'h1;
  localparam logic [10:0] EOP_TMO_BITS = 11'h4b0;
  localparam logic [3:0] EOP_SE0_BITS = 4'h2;
  localparam logic [2:0] STUFF_RUN = 3'h6;
  // apb map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam logic [11:0] REG_EP = 12'h010;
  localparam logic [1:0] RAM_SEL = 2'h1;
  localparam int ADR_SEL_HI = 11;
  localparam int ADR_SEL_LO = 10;
  localparam int ADR_WRD_HI = 9;
  localparam int ADR_WRD_LO = 2;
  localparam logic [2:0] NUM_EP = 3'h7;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PU = 1;
  localparam int CTRL_REG = 2;
  localparam int ST_CRC = 0;
  localparam int ST_STUFF = 1;
  localparam int ST_TMO = 2;
  localparam int ST_PID = 3;
  localparam int ST_TOK = 4;
  localparam int EP_DIS = 4;
  localparam int EP_RX = 3;
  localparam int EP_TX = 2;
  localparam int EP_HALT = 1;
  localparam int EP_HSHK = 0;
  // packet ids
  localparam logic [7:0] SYNC_PAT = 8'h80;
  localparam logic [7:0] PID_ACK = 8'hd2;
  localparam logic [7:0] PID_NAK = 8'h5a;
  localparam logic [7:0] PID_STALL = 8'h1e;
  localparam logic [7:0] PID_DATA0 = 8'hc3;
  localparam logic [7:0] PID_DATA1 = 8'h4b;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [1:0] PID_TOK_LO = 2'h1;
  localparam logic [2:0] PID_DAT_LO = 3'h3;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [4:0] CRC5_RES = 5'h0c;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_RES = 16'h800d;
  // descriptor table
  localparam logic [7:0] BD_SIZE = 8'h03;
  localparam logic [6:0][7:0] BD_EP_BASE = {8'h18, 8'h12, 8'h0f, 8'h0c, 8'h09, 8'h06, 8'h00};
  localparam int BUF_SHIFT = 4;
  localparam int RAM_BYTES = 256;
  localparam logic [7:0] PKT_OVH = 8'h03;

  typedef enum logic [4:0] {
    E_IDLE = 5'h01, E_RECV = 5'h02, E_FETCH = 5'h04, E_SEND = 5'h08, E_WBACK = 5'h10
  } usie_eng_t;
  typedef enum logic [3:0] {T_SYNC = 4'h1, T_DATA = 4'h2, T_CRC = 4'h4, T_EOP = 4'h8} usie_tx_t;
endpackage

// file: hdl/usie_top.sv
`timescale 1ns/1ns
module usie_top #(
  parameter int SUSPEND_CYCLES = usie_pkg::SUSPEND_CYC
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_STB,
  input wire logic RX_DP,
  input wire logic RX_DM,
  output logic TX_DP,
  output logic TX_DM,
  output logic TX_OE,
  input wire logic VBUS_VALID,
  input wire logic FIRST_SLEEP,
  input wire logic SECOND_SLEEP,
  output logic PULLUP_EN,
  output logic REG_ACTIVE,
  output logic REG_STANDBY,
  output logic REG_OFF
);
  import usie_pkg::*;

  localparam logic [16:0] SUSP_MAX = SUSPEND_CYCLES[16:0];

  typedef struct packed {
    usie_eng_t st;
    usie_tx_t tp;
    logic [2:0] ctrl;
    logic [6:0] addr;
    logic [4:0] stat;
    logic [6:0][4:0] ep;
    logic [31:0] prdata;
    logic slverr;
    logic line;
    logic [7:0] sh;
    logic [2:0] ones;
    logic [2:0] bitn;
    logic [7:0] nbyte;
    logic [10:0] nbits;
    logic [7:0] pid;
    logic [7:0] tok1;
    logic [4:0] crc5;
    logic [15:0] crc16;
    logic tok_pend;
    logic [3:0] tok_pid;
    logic [2:0] tok_ep;
    logic [7:0] bd_base;
    logic [1:0] fidx;
    logic bd_own;
    logic bd_d1;
    logic [7:0] bd_bc;
    logic [7:0] bd_buf;
    logic [7:0] tx_sh;
    logic [3:0] tx_bitn;
    logic [7:0] tx_idx;
    logic [7:0] tx_len;
    logic [7:0] tx_pid;
    logic [2:0] tx_ones;
    logic tx_line;
    logic [1:0] tx_div;
    logic tx_oe;
    logic tx_dp;
    logic tx_dm;
    logic [16:0] idle_cnt;
    logic reg_act;
    logic reg_stby;
    logic reg_off;
    logic pu;
  } usie_state_t;

  localparam usie_state_t ST_RST = '{st: E_IDLE, tp: T_SYNC, line: 1'b1, tx_line: 1'b1, reg_off: 1'b1,
                                     default: '0};

  usie_state_t s_ff;
  usie_state_t nxt_s;
  logic [7:0] ram [RAM_BYTES];
  logic eng_we;
  logic [7:0] eng_addr;
  logic [7:0] eng_wdata;
  logic [7:0] ram_q;
  logic cpu_we;
  logic sel_ram;
  logic [11:0] ep_off;
  logic ep_hit;
  logic se0;
  logic rx_bit;
  logic rx_err;
  logic susp;
  logic [3:0] ep4;
  logic [4:0] epc;
  logic halt_v;
  logic tb;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [4:0] crc5_step(logic [4:0] c, logic b);
    crc5_step = {c[3:0], 1'b0} ^ ((c[4] ^ b) ? CRC5_POLY : 5'h00);
  endfunction

  function automatic logic [15:0] crc16_step(logic [15:0] c, logic b);
    crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
  endfunction

  // ep0 alone has separate in and out entries
  function automatic logic [7:0] bd_of(logic [2:0] ep, logic dir_in);
    bd_of = BD_EP_BASE[ep] + (((ep == 3'h0) && !dir_in) ? BD_SIZE : 8'h00);
  endfunction

  function automatic usie_state_t start_tx(usie_state_t x, logic [7:0] pid, logic [7:0] len);
    usie_state_t y;
    y = x;
    y.st = E_SEND;
    y.tp = T_SYNC;
    y.tx_sh = SYNC_PAT;
    y.tx_pid = pid;
    y.tx_len = len;
    y.tx_bitn = 4'h0;
    y.tx_idx = 8'h00;
    y.tx_ones = 3'h0;
    y.tx_line = 1'b1;
    y.tx_div = 2'h0;
    y.crc16 = 16'hffff;
    start_tx = y;
  endfunction

  assign ram_q = ram[eng_addr];
  assign sel_ram = PADDR[ADR_SEL_HI:ADR_SEL_LO] == RAM_SEL;
  assign ep_off = PADDR - REG_EP;
  assign ep_hit = (PADDR >= REG_EP) && (ep_off[4:2] < NUM_EP) && (ep_off[11:5] == 7'h00) && (PADDR[1:0] == 2'h0);
  assign cpu_we = PSEL && PENABLE && PWRITE && sel_ram;
  assign se0 = !RX_DP && !RX_DM;
  assign rx_bit = RX_DP == s_ff.line;
  assign susp = s_ff.idle_cnt == SUSP_MAX;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    eng_we = 1'b0;
    eng_addr = s_ff.bd_base;
    eng_wdata = 8'h00;
    rx_err = 1'b0;
    tb = 1'b0;
    ep4 = {s_ff.sh[2:0], s_ff.tok1[7]};
    epc = s_ff.ep[s_ff.tok_ep];
    halt_v = epc[EP_HALT] && (epc[EP_RX] || epc[EP_TX]);
    // read data is captured in the setup phase so prdata comes from a flop
    if (PSEL && !PENABLE)
    begin
      nxt_s.slverr = 1'b0;
      nxt_s.prdata = 32'h0000_0000;
      if (sel_ram)
        nxt_s.prdata[7:0] = ram[PADDR[ADR_WRD_HI:ADR_WRD_LO]];
      else if (PADDR == REG_CTRL)
        nxt_s.prdata[2:0] = s_ff.ctrl;
      else if (PADDR == REG_ADDR)
        nxt_s.prdata[6:0] = s_ff.addr;
      else if (PADDR == REG_STAT)
        nxt_s.prdata[6:0] = {s_ff.tx_oe, susp, s_ff.stat};
      else if (ep_hit)
        nxt_s.prdata[4:0] = s_ff.ep[ep_off[4:2]];
      else
        nxt_s.slverr = 1'b1;
    end
    if (PSEL && PENABLE && PWRITE)
    begin
      if (PADDR == REG_CTRL)
        nxt_s.ctrl = PWDATA[2:0];
      else if (PADDR == REG_ADDR)
        nxt_s.addr = PWDATA[6:0];
      else if (PADDR == REG_STAT)
        nxt_s.stat = s_ff.stat & ~PWDATA[4:0];  // engine sets below win
      else if (ep_hit)
        nxt_s.ep[ep_off[4:2]] = PWDATA[4:0];
    end
    if (RX_STB && !se0)
      nxt_s.line = RX_DP;
    nxt_s.idle_cnt = (RX_DP && !RX_DM && !s_ff.tx_oe) ? (susp ? s_ff.idle_cnt : s_ff.idle_cnt + 17'h0_0001) : 17'h0_0000;
    nxt_s.reg_off = !s_ff.ctrl[CTRL_REG] || FIRST_SLEEP || SECOND_SLEEP;
    nxt_s.reg_stby = !nxt_s.reg_off && susp;
    nxt_s.reg_act = !nxt_s.reg_off && !susp;
    nxt_s.pu = s_ff.ctrl[CTRL_PU] && VBUS_VALID;
    if (!s_ff.ctrl[CTRL_EN])
    begin
      // disabled engine leaves the whole ram to the cpu
      nxt_s.st = E_IDLE;
      nxt_s.tok_pend = 1'b0;
      nxt_s.tx_oe = 1'b0;
    end
    else
    begin
      case (s_ff.st)
        E_IDLE:
        begin
          if (RX_STB && !se0)
          begin
            nxt_s.sh = {rx_bit, s_ff.sh[7:1]};
            if (nxt_s.sh == SYNC_PAT)
            begin
              nxt_s.st = E_RECV;
              nxt_s.ones = 3'h1;
              nxt_s.bitn = 3'h0;
              nxt_s.nbyte = 8'h00;
              nxt_s.nbits = 11'h000;
              nxt_s.crc5 = 5'h1f;
              nxt_s.crc16 = 16'hffff;
            end
          end
        end
        E_RECV:
        begin
          if (RX_STB)
          begin
            nxt_s.nbits = s_ff.nbits + 11'h001;
            if (se0)
            begin
              nxt_s.st = E_IDLE;
              if ((s_ff.pid[3:0] != ~s_ff.pid[7:4]) || (s_ff.bitn != 3'h0) || (s_ff.nbyte == 8'h00))
              begin
                nxt_s.stat[ST_PID] = 1'b1;
                rx_err = 1'b1;
              end
              else if (((s_ff.pid[1:0] == PID_TOK_LO) && (s_ff.crc5 != CRC5_RES)) ||
                       ((s_ff.pid[2:0] == PID_DAT_LO) && (s_ff.crc16 != CRC16_RES)))
              begin
                nxt_s.stat[ST_CRC] = 1'b1;
                rx_err = 1'b1;
              end
              else if (s_ff.pid[1:0] == PID_TOK_LO)
              begin
                if ((s_ff.tok1[6:0] == s_ff.addr) && (ep4 < {1'b0, NUM_EP}))
                begin
                  nxt_s.tok_pid = s_ff.pid[3:0];
                  nxt_s.tok_ep = ep4[2:0];
                  nxt_s.stat[ST_TOK] = 1'b1;
                  nxt_s.tok_pend = 1'b0;
                  nxt_s.bd_base = bd_of(ep4[2:0], s_ff.pid[3:0] == PID_IN);
                  nxt_s.fidx = 2'h0;
                  nxt_s.st = E_FETCH;
                end
              end
              else if ((s_ff.pid[2:0] == PID_DAT_LO) && s_ff.tok_pend)
              begin
                nxt_s.tok_pend = 1'b0;
                if (halt_v)
                  nxt_s = start_tx(nxt_s, PID_STALL, 8'h00);
                else if (s_ff.bd_own)
                begin
                  nxt_s.fidx = 2'h0;
                  nxt_s.st = E_WBACK;
                end
                else if (epc[EP_HSHK])
                  nxt_s = start_tx(nxt_s, PID_NAK, 8'h00);
              end
            end
            else if (s_ff.nbits == EOP_TMO_BITS)
            begin
              nxt_s.stat[ST_TMO] = 1'b1;
              rx_err = 1'b1;
              nxt_s.st = E_IDLE;
            end
            else if (s_ff.ones == STUFF_RUN)
            begin
              nxt_s.ones = 3'h0;
              if (rx_bit)
              begin
                nxt_s.stat[ST_STUFF] = 1'b1;
                rx_err = 1'b1;
                nxt_s.st = E_IDLE;
              end
            end
            else
            begin
              nxt_s.ones = rx_bit ? s_ff.ones + 3'h1 : 3'h0;
              nxt_s.sh = {rx_bit, s_ff.sh[7:1]};
              nxt_s.bitn = s_ff.bitn + 3'h1;
              if (s_ff.nbyte != 8'h00)
              begin
                nxt_s.crc5 = crc5_step(s_ff.crc5, rx_bit);
                nxt_s.crc16 = crc16_step(s_ff.crc16, rx_bit);
              end
              if (s_ff.bitn == 3'h7)
              begin
                nxt_s.nbyte = s_ff.nbyte + 8'h01;
                if (s_ff.nbyte == 8'h00)
                  nxt_s.pid = nxt_s.sh;
                else if (s_ff.nbyte == 8'h01)
                  nxt_s.tok1 = nxt_s.sh;
                // stores payload only into an owned buffer, never past its count
                if ((s_ff.nbyte != 8'h00) && ((s_ff.nbyte - 8'h01) < s_ff.bd_bc) && s_ff.tok_pend &&
                    s_ff.bd_own && !halt_v && (s_ff.pid[2:0] == PID_DAT_LO))
                begin
                  eng_we = 1'b1;
                  eng_addr = s_ff.bd_buf + s_ff.nbyte - 8'h01;
                  eng_wdata = nxt_s.sh;
                end
              end
            end
          end
        end
        E_FETCH:
        begin
          eng_addr = s_ff.bd_base + {6'h00, s_ff.fidx};
          nxt_s.fidx = s_ff.fidx + 2'h1;
          if (s_ff.fidx == 2'h0)
          begin
            nxt_s.bd_own = ram_q[7];
            nxt_s.bd_d1 = ram_q[6];
          end
          else if (s_ff.fidx == 2'h1)
            nxt_s.bd_bc = ram_q;
          else
          begin
            nxt_s.bd_buf = ram_q << BUF_SHIFT;
            nxt_s.st = E_IDLE;
            if (s_ff.tok_pid == PID_IN)
            begin
              if (!epc[EP_TX])
                nxt_s.st = E_IDLE;
              else if (halt_v)
                nxt_s = start_tx(nxt_s, PID_STALL, 8'h00);
              else if (s_ff.bd_own)
                nxt_s = start_tx(nxt_s, s_ff.bd_d1 ? PID_DATA1 : PID_DATA0, s_ff.bd_bc);
              else if (epc[EP_HSHK])
                nxt_s = start_tx(nxt_s, PID_NAK, 8'h00);
            end
            else if (((s_ff.tok_pid == PID_OUT) && epc[EP_RX]) ||
                     (epc[EP_RX] && epc[EP_TX] && !epc[EP_DIS]))
              nxt_s.tok_pend = 1'b1;
          end
        end
        E_WBACK:
        begin
          eng_we = 1'b1;
          eng_addr = s_ff.bd_base + {6'h00, s_ff.fidx};
          nxt_s.fidx = s_ff.fidx + 2'h1;
          if (s_ff.fidx == 2'h0)
            eng_wdata = {1'b0, s_ff.pid[3], s_ff.tok_pid, 2'h0};  // hand buffer back to the cpu
          else
          begin
            eng_wdata = s_ff.nbyte - PKT_OVH;
            nxt_s.st = E_IDLE;
            if (epc[EP_HSHK])
              nxt_s = start_tx(nxt_s, PID_ACK, 8'h00);
          end
        end
        E_SEND:
        begin
          eng_addr = s_ff.bd_buf + s_ff.tx_idx;
          nxt_s.tx_div = (s_ff.tx_div == TX_DIV_LAST) ? 2'h0 : s_ff.tx_div + 2'h1;
          if (s_ff.tx_div == TX_DIV_LAST)
          begin
            nxt_s.tx_oe = 1'b1;
            if (s_ff.tx_ones == STUFF_RUN)
            begin
              nxt_s.tx_ones = 3'h0;
              nxt_s.tx_line = !s_ff.tx_line;
              nxt_s.tx_dp = nxt_s.tx_line;
              nxt_s.tx_dm = !nxt_s.tx_line;
            end
            else if (s_ff.tp == T_EOP)
            begin
              nxt_s.tx_bitn = s_ff.tx_bitn + 4'h1;
              nxt_s.tx_dp = s_ff.tx_bitn == EOP_SE0_BITS;
              nxt_s.tx_dm = 1'b0;
              if (s_ff.tx_bitn > EOP_SE0_BITS)
              begin
                nxt_s.tx_oe = 1'b0;
                nxt_s.st = E_IDLE;
              end
            end
            else
            begin
              tb = (s_ff.tp == T_CRC) ? !s_ff.crc16[15] : s_ff.tx_sh[0];
              nxt_s.tx_ones = tb ? s_ff.tx_ones + 3'h1 : 3'h0;
              nxt_s.tx_line = tb ? s_ff.tx_line : !s_ff.tx_line;
              nxt_s.tx_dp = nxt_s.tx_line;
              nxt_s.tx_dm = !nxt_s.tx_line;
              nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
              nxt_s.tx_bitn = s_ff.tx_bitn + 4'h1;
              if (s_ff.tp == T_CRC)
              begin
                nxt_s.crc16 = {s_ff.crc16[14:0], 1'b0};
                if (s_ff.tx_bitn == 4'hf)
                  nxt_s.tp = T_EOP;
              end
              else
              begin
                if ((s_ff.tp == T_DATA) && (s_ff.tx_idx != 8'h00))
                  nxt_s.crc16 = crc16_step(s_ff.crc16, tb);
                if (s_ff.tx_bitn[2:0] == 3'h7)
                begin
                  nxt_s.tx_bitn = 4'h0;
                  if (s_ff.tp == T_SYNC)
                  begin
                    nxt_s.tp = T_DATA;
                    nxt_s.tx_sh = s_ff.tx_pid;
                  end
                  else if (s_ff.tx_idx == s_ff.tx_len)
                    nxt_s.tp = (s_ff.tx_pid[2:0] == PID_DAT_LO) ? T_CRC : T_EOP;
                  else
                  begin
                    nxt_s.tx_idx = s_ff.tx_idx + 8'h01;
                    nxt_s.tx_sh = ram_q;
                  end
                end
              end
            end
          end
        end
        default:
          nxt_s.st = E_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      s_ff <= ST_RST;
    else
      s_ff <= nxt_s;
  end

  // --------------------------------------------------------------------------
  // shared ram: one engine slot and one cpu slot every cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (eng_we)
      ram[eng_addr] <= eng_wdata;
    if (cpu_we)
      ram[PADDR[ADR_WRD_HI:ADR_WRD_LO]] <= PWDATA[7:0];
  end

  assign PRDATA = s_ff.prdata;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && s_ff.slverr;
  assign TX_DP = s_ff.tx_dp;
  assign TX_DM = s_ff.tx_dm;
  assign TX_OE = s_ff.tx_oe;
  assign PULLUP_EN = s_ff.pu;
  assign REG_ACTIVE = s_ff.reg_act;
  assign REG_STANDBY = s_ff.reg_stby;
  assign REG_OFF = s_ff.reg_off;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_tx_first_k;
    $rose(TX_OE) |-> !TX_DP && TX_DM;
  endproperty
  a_tx_first_k: assert property (p_tx_first_k) else $error("packet does not open with a k state");
  property p_hs_starts;
    (s_ff.st != E_SEND) ##1 (s_ff.st == E_SEND) |-> ##[1:2] TX_OE;
  endproperty
  a_hs_starts: assert property (p_hs_starts) else $error("transmitter did not start");
  property p_err_silent;
    rx_err |=> !TX_OE [*4];
  endproperty
  a_err_silent: assert property (p_err_silent) else $error("answer sent after a bad packet");
  property p_stuff_flag;
    s_ff.ctrl[CTRL_EN] && (s_ff.st == E_RECV) && RX_STB && !se0 && (s_ff.nbits != EOP_TMO_BITS) &&
      (s_ff.ones == STUFF_RUN) && rx_bit |=> s_ff.stat[ST_STUFF];
  endproperty
  a_stuff_flag: assert property (p_stuff_flag) else $error("stuffing error not flagged");
  property p_zero_wait;
    PSEL && PENABLE |-> PREADY;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("cpu access was stalled");
  property p_idle_no_ram;
    !s_ff.ctrl[CTRL_EN] |-> !eng_we;
  endproperty
  a_idle_no_ram: assert property (p_idle_no_ram) else $error("disabled engine wrote ram");
  property p_deep_off;
    FIRST_SLEEP || SECOND_SLEEP |=> REG_OFF && !REG_ACTIVE && !REG_STANDBY;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("regulator not off in deep sleep");
  property p_susp_stby;
    susp && s_ff.ctrl[CTRL_REG] && !FIRST_SLEEP && !SECOND_SLEEP |=> REG_STANDBY && !REG_ACTIVE;
  endproperty
  a_susp_stby: assert property (p_susp_stby) else $error("regulator not in standby on suspend");
  property p_active;
    !susp && s_ff.ctrl[CTRL_REG] && !FIRST_SLEEP && !SECOND_SLEEP |=> REG_ACTIVE;
  endproperty
  a_active: assert property (p_active) else $error("regulator not active");
  property p_pullup;
    PULLUP_EN |-> $past(VBUS_VALID) && $past(s_ff.ctrl[CTRL_PU]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup applied without vbus or select");
  property p_unmapped;
    PSEL && !PENABLE && !sel_ram && !ep_hit && (PADDR > REG_STAT) ##1 PSEL && PENABLE |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_data_in: cover property ((s_ff.st == E_SEND) && (s_ff.tx_pid == PID_DATA1) && (s_ff.tp == T_CRC));
  c_ack: cover property ((s_ff.st == E_WBACK) ##[1:8] (s_ff.tx_pid == PID_ACK) && TX_OE);
  c_stall: cover property ((s_ff.st == E_SEND) && (s_ff.tx_pid == PID_STALL));
  c_crc_err: cover property (rx_err && !s_ff.stat[ST_CRC] ##1 s_ff.stat[ST_CRC]);
endmodule

// file: verif/usie_host_model.sv
`timescale 1ns/1ns
module usie_host_model
(
  input wire logic CLK,
  input wire logic TX_DP,
  input wire logic TX_DM,
  input wire logic TX_OE,
  output logic RX_STB,
  output logic RX_DP,
  output logic RX_DM
);
  // -----------------------------
  // host line driver, idles at j
  // -----------------------------
  initial
  begin
    RX_STB = 1'h0;
    RX_DP = 1'h1;
    RX_DM = 1'h0;
  end
  // strobes four clocks apart, the tightest spacing allowed
  task automatic bit_out(input logic dp, input logic dm);
    @(posedge CLK);
    RX_STB <= 1'h1;
    RX_DP <= dp;
    RX_DM <= dm;
    @(posedge CLK);
    RX_STB <= 1'h0;
    repeat (2) @(posedge CLK);
  endtask
  // lsb first, a zero toggles the line
  task automatic send(input logic [15:0] bits);
    for (int i = 0; i < 16; i++)
      bit_out(bits[i] ? RX_DP : !RX_DP, bits[i] ? RX_DM : !RX_DM);
  endtask
  task automatic eop();
    bit_out(1'h0, 1'h0);
    bit_out(1'h0, 1'h0);
    bit_out(1'h1, 1'h0);
  endtask
  // reply decoder: sixteen bits sampled mid-bit from oe rising, then se0 seen
  task automatic take(output logic [16:0] got);
    logic last;
    last = 1'h1;
    do
      @(posedge CLK);
    while (TX_OE !== 1'h1);
    for (int i = 0; i < 16; i++)
    begin
      got[i] = TX_DP === last;
      last = TX_DP;
      repeat (2) @(posedge CLK);
    end
    got[16] = (TX_DP === 1'h0) && (TX_DM === 1'h0);
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
  import usie_pkg::*;
  logic CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, e, oe_seen = 0;
  logic VBUS_VALID = 1, FIRST_SLEEP = 0, SECOND_SLEEP = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic PREADY, PSLVERR, RX_STB, RX_DP, RX_DM, TX_DP, TX_DM, TX_OE;
  logic PULLUP_EN, REG_ACTIVE, REG_STANDBY, REG_OFF;
  int failures = 0, comparisons = 0, cyc = 0;
  always #25 CLK = ~CLK;
  usie_top #(.SUSPEND_CYCLES(40)) u_dut (.CLK(CLK), .NRST(NRST), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_STB(RX_STB), .RX_DP(RX_DP), .RX_DM(RX_DM), .TX_DP(TX_DP),
    .TX_DM(TX_DM), .TX_OE(TX_OE), .VBUS_VALID(VBUS_VALID), .FIRST_SLEEP(FIRST_SLEEP),
    .SECOND_SLEEP(SECOND_SLEEP), .PULLUP_EN(PULLUP_EN), .REG_ACTIVE(REG_ACTIVE),
    .REG_STANDBY(REG_STANDBY), .REG_OFF(REG_OFF));
  usie_host_model u_host (.CLK(CLK), .TX_DP(TX_DP), .TX_DM(TX_DM), .TX_OE(TX_OE), .RX_STB(RX_STB),
    .RX_DP(RX_DP), .RX_DM(RX_DM));
  // ----------------------
  // bus tasks and compares
  // ----------------------
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chkw({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do
      @(posedge CLK);
    while (PREADY !== 1'h1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  // settle: registered outputs land before they are looked at
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // in token to address 0 endpoint 0; waits first so an earlier reply has ended
  task automatic in_tok(input logic [7:0] pid);
    logic [16:0] g;
    step(8);
    u_host.send({~PID_IN, PID_IN, SYNC_PAT});
    u_host.send({8'h10, 8'h00});
    fork
      u_host.eop();
      u_host.take(g);
    join
    chkw({15'h0000, g}, {15'h0000, 1'h1, pid, SYNC_PAT});
  endtask
  // no reply may follow the bad packet of the first half
  always @(posedge CLK)
  begin
    cyc++;
    if (TX_OE === 1'h1)
      oe_seen <= 1'h1;
    if (cyc == 3000)
    begin
      failures++;
      close_out();
    end
  end
  // ----------
  // scenarios
  // ----------
  initial
  begin
    repeat (2) @(posedge CLK);
    NRST <= 1'h1;
    step(1);
    chkb(REG_OFF, 1'h1);
    chkb(PULLUP_EN, 1'h0);
    apb(1'h1, REG_CTRL, 32'h0000_0007);
    step(2);
    chkb(PULLUP_EN, 1'h1);
    chkb(REG_ACTIVE, 1'h1);
    @(posedge CLK);
    VBUS_VALID <= 1'h0;
    step(2);
    chkb(PULLUP_EN, 1'h0);
    @(posedge CLK);
    VBUS_VALID <= 1'h1;
    u_host.send({8'hff, 8'h80});
    u_host.eop();
    step(1);
    chkb(REG_ACTIVE, 1'h1);
    apb(1'h0, REG_STAT, 32'h0000_0000);
    chkw(q & 32'h0000_0002, 32'h0000_0002);
    apb(1'h1, REG_STAT, 32'h0000_001f);
    apb(1'h0, REG_STAT, 32'h0000_0000);
    chkw(q & 32'h0000_001f, 32'h0000_0000);
    step(60);
    chkb(REG_STANDBY, 1'h1);
    chkb(oe_seen, 1'h0);
    @(posedge CLK);
    FIRST_SLEEP <= 1'h1;
    step(2);
    chkb(REG_OFF, 1'h1);
    @(posedge CLK);
    FIRST_SLEEP <= 1'h0;
    SECOND_SLEEP <= 1'h1;
    step(2);
    chkb(REG_OFF, 1'h1);
    @(posedge CLK);
    SECOND_SLEEP <= 1'h0;
    apb(1'h1, REG_CTRL, 32'h0000_0000);
    step(2);
    chkb(REG_OFF, 1'h1);
    chkb(PULLUP_EN, 1'h0);
    apb(1'h1, 12'h500, 32'h1234_56a5);
    apb(1'h0, 12'h500, 32'h0000_0000);
    chkw(q, 32'h0000_00a5);
    apb(1'h0, 12'h00c, 32'h0000_0000);
    chkb(e, 1'h1);
    chkw(q, 32'h0000_0000);
    // ep0 in descriptor not owned, so a good in token earns a nak
    apb(1'h1, 12'h400, 32'h0000_0000);
    apb(1'h1, REG_EP, 32'h0000_000d);
    apb(1'h1, REG_CTRL, 32'h0000_0001);
    // damaged crc field: flagged, token not taken, no reply
    u_host.send({~PID_IN, PID_IN, SYNC_PAT});
    u_host.send({8'h18, 8'h00});
    u_host.eop();
    apb(1'h0, REG_STAT, 32'h0000_0000);
    chkw(q & 32'h0000_0051, 32'h0000_0001);
    in_tok(PID_NAK);
    apb(1'h1, REG_EP, 32'h0000_000f);
    in_tok(PID_STALL);
    close_out();
  end
endmodule
